// *** logic/serial_port_pkg.sv ***
// Constants, state type and bit-voting helpers for the asynchronous serial core.
// Assumes one clock and a 16x baud enable pulse from a shared baud generator.
package serial_port_pkg;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned FRAME_W        = 11;
   localparam logic [3:0]  LEN_EIGHT      = 4'hA;  // Start, 8 data, stop.
   localparam logic [3:0]  LEN_NINE       = 4'hB;  // Start, 9 data, stop.
   localparam logic [3:0]  LEN_ONE        = 4'h1;
   localparam logic [3:0]  DIV_LAST       = 4'hF;  // 16 oversampling ticks per bit.
   localparam logic [4:0]  RT_ZERO        = 5'h00;
   localparam logic [4:0]  RT_FIRST       = 5'h01;
   localparam logic [4:0]  RT_S3          = 5'h03;
   localparam logic [4:0]  RT_S5          = 5'h05;
   localparam logic [4:0]  RT_S7          = 5'h07;
   localparam logic [4:0]  RT_S8          = 5'h08;
   localparam logic [4:0]  RT_S9          = 5'h09;
   localparam logic [4:0]  RT_S10         = 5'h0A;
   localparam logic [4:0]  RT_LAST        = 5'h10;
   localparam logic [4:0]  RT_RESYNC_BASE = 5'h0C;
   localparam logic        TBE_RST        = 1'b1;
   localparam logic        TC_RST         = 1'b1;

   typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_state_t;

   // Majority of three samples.
   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // True when the three samples disagree.
   function automatic logic split3(input logic [2:0] s);
      return (s != 3'h0) && (s != 3'h7);
   endfunction
endpackage : serial_port_pkg

// *** logic/tx_frame_if.sv ***
// Frame hand-off between the transmit control and the transmit shifter.
// Assumes both ends run on ref_clk; the control end makes the bit enable.
interface tx_frame_if;
   import serial_port_pkg::*;
   logic               bit_tick;  // One-cycle enable per bit time.
   logic               load;      // Take frame at this bit enable.
   logic               flush;     // Abandon any frame at once.
   logic [FRAME_W-1:0] frame;     // Bits to send, LSB first.
   logic [3:0]         len;       // Number of bits in frame.
   logic               busy;      // A frame is on the line.
   logic               last;      // The final bit is on the line.
   logic               line;      // Uninverted line level.

   modport ctrl  (output bit_tick, load, flush, frame, len, input busy, last, line);
   modport shift (input bit_tick, load, flush, frame, len, output busy, last, line);
endinterface : tx_frame_if

// *** logic/rx_pin_sync.sv ***
// Two-stage synchroniser for the receive pin.
// Assumes the pin is asynchronous to ref_clk; only the second stage is read.
module rx_pin_sync (
   input  wire logic ref_clk,  // System clock.
   input  wire logic rst,      // Asynchronous reset, active high.
   input  wire logic rx_pin,   // Raw receive pin.
   output logic      rx_sync   // Pin level in the clock domain.
);
   logic meta_ff;

   // The line idles high, so both stages reset to 1 to avoid a false start edge.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         meta_ff <= rx_pin;
         rx_sync <= meta_ff;
      end
   end
endmodule // rx_pin_sync

// *** logic/tx_shifter.sv ***
// Transmit shift register: sends a frame LSB first, one bit per bit enable.
// Assumes the control end only loads on a bit enable when idle or on the last bit.
module tx_shifter (
   input  wire logic ref_clk,  // System clock.
   input  wire logic rst,      // Asynchronous reset, active high.
   tx_frame_if.shift link      // Frame hand-off.
);
   import serial_port_pkg::*;

   logic [FRAME_W-1:0] sr_ff;
   logic [3:0]         cnt_ff;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sr_ff  <= '1;
         cnt_ff <= 4'h0;
      end else if (link.flush) begin
         sr_ff  <= '1;
         cnt_ff <= 4'h0;
      end else if (link.bit_tick) begin
         if (link.load) begin
            sr_ff  <= link.frame;
            cnt_ff <= link.len;
         end else if (cnt_ff != 4'h0) begin
            sr_ff  <= {1'b1, sr_ff[FRAME_W-1:1]};
            cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end

   assign link.busy = (cnt_ff != 4'h0);
   assign link.last = (cnt_ff == 4'h1);
   assign link.line = (cnt_ff == 4'h0) | sr_ff[0];
endmodule // tx_shifter

// *** logic/async_serial_tx_rx_core.sv ***
// Asynchronous NRZ serial transmitter and receiver with its status flags.
// Assumes rt_tick is a one-cycle pulse at 16x the baud rate on ref_clk and
// that the CPU side strobes come from logic on ref_clk.

// Function
// - Characters of 8 or 9 bits, ninth from tx_ninth_bit.
// - Preamble of ones, then framed data start0 stop1.
// - Buffer-to-shifter transfer sets tx_buffer_empty, may interrupt.
// - Status read then data write clears tx_buffer_empty.
// - Transmit line idles at logic one.
// - Port disable releases both pins at once.
// - Send break loads all-zero character, length by mode.
// - Break repeats; after it at least one one.
// - Zero start, data and stop means break.
// - Break sets error, full, break flags, clears data.
// - Idle character all ones; one begins each transmission.
// - Transmit disable finishes current character, then idle.
// - Disable then enable queues one idle character.
// - Polarity invert flips every transmitted level.
// - Transmission complete when everything is empty, may interrupt.
// - Receive ninth bit: bit 8, or copy of 7.
// - Full character moves to buffer, sets full flag.
// - Oversample 16x, resync on start and falling bits.
// - Start edge is zero after three ones.
// - Start verified by samples 3, 5, 7.
// - Failed start verification returns to search.
// - Data bit by majority of 8, 9, 10.
// - Stop bit majority zero is framing error.
module async_serial_tx_rx_core (
   input  wire logic                                ref_clk,              // System clock.
   input  wire logic                                rst,                  // Async reset, high.
   input  wire logic                                rt_tick,              // 16x baud enable.
   input  wire logic                                port_enable,          // Serial port on.
   input  wire logic                                tx_enable,            // Transmitter on.
   input  wire logic                                char_len_nine,        // 1 = 9-bit data.
   input  wire logic                                tx_ninth_bit,         // Transmit bit 8.
   input  wire logic                                tx_polarity_invert,   // Invert tx line.
   input  wire logic                                send_break,           // Send breaks.
   input  wire logic                                tx_empty_irq_en,      // Empty irq enable.
   input  wire logic                                tx_done_irq_en,       // Done irq enable.
   input  wire logic                                rx_full_irq_en,       // Full irq enable.
   input  wire logic                                status_rd,            // Status read strobe.
   input  wire logic                                data_wr,              // Data write strobe.
   input  wire logic [serial_port_pkg::DATA_W-1:0]  data_wr_val,          // Data written.
   input  wire logic                                data_rd,              // Data read strobe.
   input  wire logic                                rx_pin,               // Receive pin.
   output logic                                     tx_pin_out,           // Transmit pin level.
   output logic                                     tx_pin_oe,            // Transmit pin driven.
   output logic                                     rx_pin_owned,         // Rx pin in use.
   output logic                                     tx_buffer_empty,      // Buffer can take data.
   output logic                                     tx_done_flag,         // All sent.
   output logic                                     rx_full_flag,         // Character ready.
   output logic                                     framing_err_flag,     // Bad stop bit.
   output logic                                     noise_flag,           // Samples disagreed.
   output logic                                     break_detected_flag,  // Break received.
   output logic                                     overrun_flag,         // Character lost.
   output logic                                     rx_in_progress_flag,  // Receiving.
   output logic [serial_port_pkg::DATA_W-1:0]       data_buffer_reg,      // Received data.
   output logic                                     rx_ninth_bit,         // Received bit 8.
   output logic                                     tx_irq,               // Transmitter irq.
   output logic                                     rx_irq                // Receiver irq.
);
   import serial_port_pkg::*;

   tx_frame_if link ();

   logic [3:0]        div_ff;
   logic [DATA_W-1:0] buf_ff;
   logic              buf_full_ff;
   logic              tx_arm_ff;
   logic              te_q_ff;
   logic              idle_pend_ff;
   logic              one_pend_ff;
   logic              bit_tick;
   logic              slot;
   logic              wr_ok;
   logic              ld_idle;
   logic              ld_brk;
   logic              ld_one;
   logic              ld_data;
   logic [3:0]        len_sel;
   logic              rx_s;
   rx_state_t         st_ff;
   logic [4:0]        rt_ff;
   logic [3:0]        bit_ff;
   logic [2:0]        hist_ff;
   logic [2:0]        smp_ff;
   logic [8:0]        sh_ff;
   logic              noise_acc_ff;
   logic              prev_ff;
   logic              zero_seen_ff;
   logic [4:0]        edge_ff;
   logic              all_zero_ff;
   logic              rx_arm_ff;
   logic [2:0]        pat;
   logic              bit_v;
   logic              start_edge;
   logic              at_stop;
   logic              rx_fin;
   logic              resync;
   logic              brk;
   logic              rx_clr;
   logic              keep_old;

   function automatic logic [4:0] inc_rt(input logic [4:0] r);
      return (r == RT_LAST) ? RT_FIRST : r + 5'h01;
   endfunction

   rx_pin_sync u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .rx_pin  (rx_pin),
      .rx_sync (rx_s)
   );

   tx_shifter u_shift (
      .ref_clk (ref_clk),
      .rst     (rst),
      .link    (link)
   );

   // Transmit side.
   assign len_sel  = char_len_nine ? LEN_NINE : LEN_EIGHT;
   assign bit_tick = rt_tick && (div_ff == DIV_LAST);
   assign slot     = bit_tick && (!link.busy || link.last);
   assign wr_ok    = data_wr && tx_arm_ff;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_ff <= 4'h0;
      end else if (!port_enable) begin
         div_ff <= 4'h0;
      end else if (rt_tick) begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // Disabling the transmitter only blocks new loads, so the frame on the line finishes.
   always_comb begin
      ld_idle = 1'b0;
      ld_brk  = 1'b0;
      ld_one  = 1'b0;
      ld_data = 1'b0;
      if (slot && tx_enable && port_enable) begin
         if (idle_pend_ff) begin
            ld_idle = 1'b1;
         end else if (send_break) begin
            ld_brk = 1'b1;
         end else if (one_pend_ff) begin
            ld_one = 1'b1;
         end else if (buf_full_ff) begin
            ld_data = 1'b1;
         end
      end
   end

   assign link.bit_tick = bit_tick;
   assign link.load     = ld_idle | ld_brk | ld_one | ld_data;
   assign link.flush    = !port_enable;
   assign link.len      = ld_one ? LEN_ONE : len_sel;
   assign link.frame    = ld_brk  ? '0 :
                          ld_data ? {1'b1, char_len_nine ? tx_ninth_bit : 1'b1, buf_ff, 1'b0} :
                          '1;

   // A rising edge of tx_enable while port_enable is high queues an idle character: the preamble or a requeue.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         te_q_ff      <= 1'b0;
         idle_pend_ff <= 1'b0;
         one_pend_ff  <= 1'b0;
      end else begin
         te_q_ff      <= tx_enable;
         idle_pend_ff <= port_enable & ((tx_enable & !te_q_ff) | (idle_pend_ff & !ld_idle));
         one_pend_ff  <= port_enable & (ld_brk | (one_pend_ff & !ld_one));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         buf_ff          <= '0;
         buf_full_ff     <= 1'b0;
         tx_buffer_empty <= TBE_RST;
         tx_arm_ff       <= 1'b0;
      end else begin
         if (status_rd && tx_buffer_empty) begin
            tx_arm_ff <= 1'b1;
         end else if (data_wr) begin
            tx_arm_ff <= 1'b0;
         end
         if (wr_ok) begin
            buf_ff <= data_wr_val;
         end
         buf_full_ff     <= wr_ok | (buf_full_ff & !ld_data);
         tx_buffer_empty <= ld_data | (tx_buffer_empty & !wr_ok);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_done_flag <= TC_RST;
         tx_pin_out   <= 1'b1;
         tx_pin_oe    <= 1'b0;
         rx_pin_owned <= 1'b0;
         tx_irq       <= 1'b0;
      end else begin
         tx_done_flag <= !link.busy && !link.load && !buf_full_ff && !send_break
                         && !idle_pend_ff && !one_pend_ff;
         tx_pin_out   <= link.line ^ tx_polarity_invert;
         tx_pin_oe    <= port_enable;
         rx_pin_owned <= port_enable;
         tx_irq       <= (tx_buffer_empty & tx_empty_irq_en) | (tx_done_flag & tx_done_irq_en);
      end
   end

   // Receive side.
   assign pat        = {smp_ff[1:0], rx_s};
   assign bit_v      = maj3(pat);
   assign start_edge = (hist_ff == 3'h7) && !rx_s;
   assign at_stop    = (bit_ff == len_sel - 4'h1);
   assign rx_fin     = rt_tick && (st_ff == RX_BITS) && (rt_ff == RT_S10) && at_stop;
   assign resync     = prev_ff && !bit_v && zero_seen_ff;
   assign brk        = all_zero_ff && !bit_v;

   // rt_ff is the index of the sample taken at the current tick.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff   <= RX_HUNT;
         rt_ff   <= RT_ZERO;
         hist_ff <= 3'h0;
         bit_ff  <= 4'h0;
      end else if (!port_enable) begin
         st_ff   <= RX_HUNT;
         rt_ff   <= RT_ZERO;
         hist_ff <= 3'h0;
      end else if (rt_tick) begin
         case (st_ff)
            RX_HUNT: begin
               hist_ff <= {hist_ff[1:0], rx_s};
               if (start_edge) begin
                  st_ff  <= RX_START;
                  rt_ff  <= inc_rt(RT_FIRST);
                  bit_ff <= 4'h0;
               end
            end
            RX_START: begin
               if (rt_ff == RT_S7 && bit_v) begin
                  st_ff   <= RX_HUNT;
                  rt_ff   <= RT_ZERO;
                  hist_ff <= 3'h0;
               end else if (rt_ff == RT_LAST) begin
                  st_ff  <= RX_BITS;
                  rt_ff  <= RT_FIRST;
                  bit_ff <= 4'h1;
               end else begin
                  rt_ff <= inc_rt(rt_ff);
               end
            end
            RX_BITS: begin
               if (rt_ff == RT_S10) begin
                  bit_ff <= bit_ff + 4'h1;
                  if (at_stop) begin
                     st_ff   <= RX_HUNT;
                     rt_ff   <= RT_ZERO;
                     hist_ff <= 3'h0;
                  end else if (resync) begin
                     rt_ff <= RT_RESYNC_BASE - edge_ff;
                  end else begin
                     rt_ff <= inc_rt(rt_ff);
                  end
               end else begin
                  rt_ff <= inc_rt(rt_ff);
               end
            end
            default: begin
               st_ff <= RX_HUNT;
               rt_ff <= RT_ZERO;
            end
         endcase
      end
   end

   // Only the first falling sample of a bit is kept; it marks where the edge really was.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         smp_ff       <= 3'h0;
         sh_ff        <= '0;
         noise_acc_ff <= 1'b0;
         prev_ff      <= 1'b0;
         zero_seen_ff <= 1'b0;
         edge_ff      <= RT_ZERO;
         all_zero_ff  <= 1'b1;
      end else if (rt_tick && st_ff == RX_HUNT && start_edge) begin
         noise_acc_ff <= 1'b0;
         prev_ff      <= 1'b0;
         zero_seen_ff <= 1'b0;
         all_zero_ff  <= 1'b1;
      end else if (rt_tick && st_ff != RX_HUNT) begin
         if (rt_ff == RT_S3 || rt_ff == RT_S5 || rt_ff == RT_S8 || rt_ff == RT_S9) begin
            smp_ff <= {smp_ff[1:0], rx_s};
         end
         if (st_ff == RX_BITS && rt_ff <= RT_S10 && !rx_s && !zero_seen_ff) begin
            zero_seen_ff <= 1'b1;
            edge_ff      <= rt_ff;
         end
         if (st_ff == RX_START && rt_ff == RT_S7) begin
            noise_acc_ff <= split3(pat);
         end
         if (st_ff == RX_START && rt_ff == RT_S10 && pat != 3'h0) begin
            noise_acc_ff <= 1'b1;
         end
         if (st_ff == RX_BITS && rt_ff == RT_S10) begin
            zero_seen_ff <= 1'b0;
            prev_ff      <= bit_v;
            if (split3(pat)) begin
               noise_acc_ff <= 1'b1;
            end
            if (!at_stop) begin
               sh_ff <= {bit_v, sh_ff[8:1]};
               if (bit_v) begin
                  all_zero_ff <= 1'b0;
               end
            end
         end
      end
   end

   // A completed character sets flags in the same cycle as a clear; the set wins.
   assign rx_clr   = data_rd && rx_arm_ff;
   assign keep_old = rx_full_flag && !rx_clr;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_arm_ff           <= 1'b0;
         rx_full_flag        <= 1'b0;
         framing_err_flag    <= 1'b0;
         noise_flag          <= 1'b0;
         break_detected_flag <= 1'b0;
         overrun_flag        <= 1'b0;
         data_buffer_reg     <= '0;
         rx_ninth_bit        <= 1'b0;
         rx_in_progress_flag <= 1'b0;
         rx_irq              <= 1'b0;
      end else begin
         if (status_rd && rx_full_flag) begin
            rx_arm_ff <= 1'b1;
         end else if (data_rd) begin
            rx_arm_ff <= 1'b0;
         end
         rx_full_flag        <= rx_fin | (rx_full_flag & !rx_clr);
         framing_err_flag    <= (rx_fin & !bit_v) | (framing_err_flag & !rx_clr);
         noise_flag          <= (rx_fin & (noise_acc_ff | split3(pat))) | (noise_flag & !rx_clr);
         break_detected_flag <= (rx_fin & brk) | (break_detected_flag & !rx_clr);
         overrun_flag        <= (rx_fin & keep_old) | (overrun_flag & !rx_clr);
         if (rx_fin && !keep_old) begin
            if (brk) begin
               data_buffer_reg <= '0;
               rx_ninth_bit    <= 1'b0;
            end else begin
               data_buffer_reg <= char_len_nine ? sh_ff[7:0] : sh_ff[8:1];
               rx_ninth_bit    <= sh_ff[8];
            end
         end
         rx_in_progress_flag <= (st_ff != RX_HUNT);
         rx_irq              <= rx_full_flag & rx_full_irq_en;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_idle_line;
      !link.busy |=> tx_pin_out == !$past(tx_polarity_invert);
   endproperty
   a_idle_line: assert property (p_idle_line)
      else $error("Idle transmit line not at idle level.");

   property p_release;
      !port_enable |=> !tx_pin_oe && !rx_pin_owned;
   endproperty
   a_release: assert property (p_release)
      else $error("Pins not released after port disable.");

   property p_empty_set;
      ld_data |=> tx_buffer_empty && !buf_full_ff ##1 link.busy;
   endproperty
   a_empty_set: assert property (p_empty_set)
      else $error("Buffer transfer did not set empty flag.");

   property p_empty_clear;
      (tx_buffer_empty && status_rd) ##1 (data_wr && !status_rd) |=> !tx_buffer_empty;
   endproperty
   a_empty_clear: assert property (p_empty_clear)
      else $error("Read then write did not clear empty flag.");

   property p_break_char;
      ld_brk |-> link.frame == '0 && link.len == len_sel;
   endproperty
   a_break_char: assert property (p_break_char)
      else $error("Break character has wrong content or length.");

   property p_break_tail;
      ld_one |-> !send_break && $past(one_pend_ff) && link.frame[0] && link.len == LEN_ONE;
   endproperty
   a_break_tail: assert property (p_break_tail)
      else $error("Break not followed by a single one bit.");

   property p_reject;
      port_enable && rt_tick && st_ff == RX_START && rt_ff == RT_S7 && bit_v
         |=> st_ff == RX_HUNT && rt_ff == RT_ZERO;
   endproperty
   a_reject: assert property (p_reject)
      else $error("Rejected start bit did not restart search.");

   property p_break_rx;
      rx_fin && brk && !rx_full_flag |=> data_buffer_reg == '0 && !rx_ninth_bit
         && break_detected_flag && framing_err_flag && rx_full_flag;
   endproperty
   a_break_rx: assert property (p_break_rx)
      else $error("Received break did not update flags and data.");

   property p_ninth;
      rx_fin && !brk && !rx_full_flag |=> rx_ninth_bit == $past(sh_ff[8]) && rx_full_flag;
   endproperty
   a_ninth: assert property (p_ninth)
      else $error("Receive ninth bit wrong.");
endmodule // async_serial_tx_rx_core

// *** verification/serial_peer.sv ***
// Remote serial transceiver model: sends frames on rx line, decodes the tx line.
// Assumes rt_tick is the 16x baud enable on ref_clk and an idle-high line.
module serial_peer (
   input  wire logic ref_clk,   // System clock.
   input  wire logic rt_tick,   // 16x baud enable.
   input  wire logic line_in,   // Device transmit line.
   output logic      line_out,  // Device receive line.
   output logic [7:0] got       // Last byte decoded.
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk iff rt_tick);
   endtask
   // Frame bits go out LSB first, 16 ticks each; the line then idles high.
   task automatic send(input logic [10:0] fr);
      for (int i = 0; i < 11; i++) begin
         line_out <= fr[i];
         ticks(16);
      end
      line_out <= 1'b1;
   endtask
   initial begin
      line_out = 1'b1;
      got = 8'h00;
      forever begin
         @(negedge line_in);
         ticks(8);
         for (int i = 0; i < 8; i++) begin
            ticks(16);
            got[i] = line_in;
         end
      end
   end
endmodule // serial_peer

// *** verification/async_serial_tx_rx_core_tb.sv ***
// Self-checking bench for the serial core: receive, break, transmit, pins.
// Assumes the serial_peer model on the line and a 125 MHz clock.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module async_serial_tx_rx_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst = 1'b1, rt_tick = 1'b0, port_enable = 1'b0, tx_enable = 1'b0;
   logic inv = 1'b0, irq_en = 1'b0, status_rd = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
   logic brk = 1'b0, nine = 1'b0, owned, overrun_flag, rx_busy;
   logic [7:0] wval = 8'h00, data_buffer_reg;
   logic tx_pin_out, tx_pin_oe, tx_buffer_empty, tx_done_flag, rx_full_flag, rx_line;
   logic framing_err_flag, noise_flag, break_detected_flag, rx_ninth_bit, tx_irq, rx_irq;
   int fail_count = 0, comparisons = 0;
   async_serial_tx_rx_core i_async_serial_tx_rx_core (.ref_clk, .rst, .rt_tick,
      .port_enable, .tx_enable, .char_len_nine(nine), .tx_ninth_bit(nine),
      .tx_polarity_invert(inv), .send_break(brk), .tx_empty_irq_en(irq_en),
      .tx_done_irq_en(irq_en), .rx_full_irq_en(irq_en), .status_rd, .data_wr,
      .data_wr_val(wval), .data_rd, .rx_pin(rx_line), .tx_pin_out, .tx_pin_oe,
      .rx_pin_owned(owned), .tx_buffer_empty, .tx_done_flag, .rx_full_flag, .framing_err_flag,
      .noise_flag, .break_detected_flag, .overrun_flag, .rx_in_progress_flag(rx_busy),
      .data_buffer_reg, .rx_ninth_bit, .tx_irq, .rx_irq);
   // The released transmit pin is pulled up.
   serial_peer i_serial_peer (.ref_clk, .rt_tick, .line_in(tx_pin_oe ? tx_pin_out : 1'b1),
      .line_out(rx_line), .got());
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) rt_tick <= ~rt_tick;
   task automatic rx_read;
      status_rd <= 1'b1;
      @(posedge ref_clk);
      status_rd <= 1'b0;
      data_rd   <= 1'b1;
      @(posedge ref_clk);
      data_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic tx_write(input logic [7:0] v);
      status_rd <= 1'b1;
      @(posedge ref_clk);
      status_rd <= 1'b0;
      wval      <= v;
      data_wr   <= 1'b1;
      @(posedge ref_clk);
      data_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK("tx_pin_out", 1'b1, tx_pin_out)
      `CHK("tx_buffer_empty", 1'b1, tx_buffer_empty)
      `CHK("tx_pin_oe", 1'b0, tx_pin_oe)
      `CHK("rx_pin_owned", 1'b0, owned)
      port_enable <= 1'b1;
      inv <= 1'b1;
      irq_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("tx_pin_out", 1'b0, tx_pin_out)
      `CHK("tx_pin_oe", 1'b1, tx_pin_oe)
      `CHK("rx_pin_owned", 1'b1, owned)
      inv <= 1'b0;
      i_serial_peer.send({2'b11, 8'hA5, 1'b0});
      repeat (4) @(posedge ref_clk);
      `CHK("rx_full_flag", 1'b1, rx_full_flag)
      `CHK("data_buffer_reg", 8'hA5, data_buffer_reg)
      `CHK("rx_ninth_bit", 1'b1, rx_ninth_bit)
      `CHK("framing_err_flag", 1'b0, framing_err_flag)
      `CHK("noise_flag", 1'b0, noise_flag)
      `CHK("rx_irq", 1'b1, rx_irq)
      rx_read();
      `CHK("rx_full_flag", 1'b0, rx_full_flag)
      fork
         i_serial_peer.send(11'h400);
         begin
            repeat (100) @(posedge ref_clk);
            `CHK("rx_in_progress_flag", 1'b1, rx_busy)
         end
      join
      repeat (4) @(posedge ref_clk);
      `CHK("break_detected_flag", 1'b1, break_detected_flag)
      `CHK("framing_err_flag", 1'b1, framing_err_flag)
      `CHK("rx_full_flag", 1'b1, rx_full_flag)
      `CHK("data_buffer_reg", 8'h00, data_buffer_reg)
      `CHK("rx_ninth_bit", 1'b0, rx_ninth_bit)
      // The break is still unread, so this character is lost to overrun.
      i_serial_peer.send({2'b11, 8'hA5, 1'b0});
      repeat (4) @(posedge ref_clk);
      `CHK("overrun_flag", 1'b1, overrun_flag)
      `CHK("data_buffer_reg", 8'h00, data_buffer_reg)
      rx_read();
      `CHK("overrun_flag", 1'b0, overrun_flag)
      nine <= 1'b1;
      i_serial_peer.send({2'b11, 8'h69, 1'b0});
      repeat (4) @(posedge ref_clk);
      `CHK("data_buffer_reg", 8'h69, data_buffer_reg)
      `CHK("rx_ninth_bit", 1'b1, rx_ninth_bit)
      `CHK("framing_err_flag", 1'b0, framing_err_flag)
      rx_read();
      nine <= 1'b0;
      tx_enable <= 1'b1;
      @(posedge ref_clk);
      tx_write(8'h3C);
      `CHK("tx_buffer_empty", 1'b0, tx_buffer_empty)
      tx_enable <= 1'b0;
      @(posedge ref_clk);
      tx_enable <= 1'b1;
      for (int i = 0; i < 2000 && tx_done_flag !== 1'b1; i++) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
      `CHK("peer byte", 8'h3C, i_serial_peer.got)
      `CHK("tx_buffer_empty", 1'b1, tx_buffer_empty)
      `CHK("tx_done_flag", 1'b1, tx_done_flag)
      `CHK("tx_irq", 1'b1, tx_irq)
      `CHK("tx_pin_out", 1'b1, tx_pin_out)
      brk <= 1'b1;
      for (int i = 0; i < 100 && tx_pin_out !== 1'b0; i++) @(posedge ref_clk);
      brk <= 1'b0;
      tx_write(8'h5A);
      for (int i = 0; i < 1000 && tx_buffer_empty !== 1'b1; i++) @(posedge ref_clk);
      `CHK("peer byte", 8'h00, i_serial_peer.got)
      for (int i = 0; i < 1000 && tx_done_flag !== 1'b1; i++) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
      `CHK("peer byte", 8'h5A, i_serial_peer.got)
      port_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK("tx_pin_oe", 1'b0, tx_pin_oe)
      `CHK("rx_pin_owned", 1'b0, owned)
      final_report();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      final_report();
   end
endmodule // async_serial_tx_rx_core_tb
